// File: testbench.sv
`timescale 1ns/1ps
module testbench
	import txsv_pkg::*;
;
	logic        clk_i = 1'b0, nrst_i = 1'b0;
	logic        frm_byte_i = 1'b0, frm_end_i = 1'b0, frm_underrun_i = 1'b0;
	logic        frm_error_i = 1'b0, frm_pause_sw_i = 1'b0;
	logic [7:0]  frm_data_i = 8'h00, paddr_i = 8'h00;
	logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
	logic [31:0] pwdata_i = 32'h0, prdata_o, stat_vec_o, frames, bytes, live;
	logic        pready_o, pslverr_o, stat_vld_o, irq_o;
	int          fails = 0, check_count = 0, cyc = 0, nfr = 0, exp_bytes = 0, exp_live = 0;

	always #4 clk_i = ~clk_i;

	txsv_top i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .frm_byte_i(frm_byte_i), .frm_data_i(frm_data_i),
		.frm_end_i(frm_end_i), .frm_underrun_i(frm_underrun_i), .frm_error_i(frm_error_i),
		.frm_pause_sw_i(frm_pause_sw_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
		.paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .stat_vec_o(stat_vec_o), .stat_vld_o(stat_vld_o), .irq_o(irq_o));

	txsv_cnt_model i_cnt (.clk_i(clk_i), .nrst_i(nrst_i), .vec_i(stat_vec_o), .vld_i(stat_vld_o),
		.frames_o(frames), .bytes_o(bytes), .live_o(live));

	////////////////////////////////////////////////////////////
	task automatic wrap_up;
		$display("Checks %0d, mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	// Request held until pready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic er);
		@(posedge clk_i);
		psel_i    <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i  <= wr;
		paddr_i   <= a;
		pwdata_i  <= wd;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do @(posedge clk_i); while (pready_o !== 1'b1);
		rd = prdata_o;
		er = pslverr_o;
		psel_i    <= 1'b0;
		penable_i <= 1'b0;
	endtask : apb

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic er_exp);
		logic [31:0] rd;
		logic        er;
		apb(1'b0, a, 32'h0, rd, er);
		chk(rd, exp, "read data");
		chk(32'(er), 32'(er_exp), "slave error");
	endtask : rdchk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic        er;
		apb(1'b1, a, d, rd, er);
	endtask : wr

	////////////////////////////////////////////////////////////
	// Error flags rise on the last byte and stay through the end cycle, the latest moment allowed
	task automatic frame(input int n, input logic [7:0] d0, input logic [7:0] d1, input logic [15:0] ty,
		input logic und, input logic err, input logic pse, input logic tag);
		logic [13:0] ln;
		logic [31:0] ev;
		ln = (n > 16383) ? LEN_MAX : 14'(n);
		ev = {pse, 11'h000, tag, ln, ty == 16'h8808, und, d0[0], d0 == 8'hff && d1 == 8'hff, !(und | err)};
		for (int i = 0; i < n; i++) begin
			@(posedge clk_i);
			frm_byte_i <= 1'b1;
			frm_data_i <= (i == 0) ? d0 : (i < 6) ? d1 : (i == 12) ? ty[15:8] : (i == 13) ? ty[7:0] : 8'(i);
			frm_underrun_i <= (i == n - 1) && und;
			frm_error_i    <= (i == n - 1) && err;
			frm_pause_sw_i <= (i == n - 1) && pse;
			if (i > 0) begin
				#1;
				chk(32'({stat_vld_o, stat_vec_o[30]}), 32'h1, "live flag in frame");
			end
		end
		@(posedge clk_i);
		frm_byte_i     <= 1'b0;
		frm_end_i      <= 1'b1;
		frm_underrun_i <= und;
		frm_error_i    <= err;
		frm_pause_sw_i <= pse;
		@(posedge clk_i);
		frm_end_i      <= 1'b0;
		frm_underrun_i <= 1'b0;
		frm_error_i    <= 1'b0;
		frm_pause_sw_i <= 1'b0;
		#1;
		chk(32'(stat_vld_o), 32'h1, "strobe");
		chk(stat_vec_o, ev, "vector");
		@(posedge clk_i);
		#1;
		chk(32'(stat_vld_o), 32'h0, "strobe width");
		chk(stat_vec_o, ev, "vector hold");
		nfr++;
		exp_live += n;
		exp_bytes += int'(ln);
	endtask : frame

	////////////////////////////////////////////////////////////
	// Ceiling sized for one 16400-byte frame plus the short ones
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 40000) begin
			fails++;
			wrap_up();
		end
	end

	initial begin
		repeat (5) @(posedge clk_i);
		nrst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rdchk(OFS_CTRL, 32'h0, 1'b0);
		rdchk(OFS_INT_MASK, 32'h0, 1'b0);
		rdchk(OFS_LAST_VEC, 32'h0, 1'b0);
		rdchk(8'h14, 32'h0, 1'b1);
		frame(64, 8'hff, 8'hff, 16'h0800, 1'b0, 1'b0, 1'b0, 1'b0);
		frame(60, 8'h01, 8'h80, 16'h8808, 1'b0, 1'b0, 1'b1, 1'b0);
		frame(68, 8'h02, 8'h11, 16'h8100, 1'b0, 1'b0, 1'b0, 1'b0);
		wr(OFS_CTRL, 32'h1);
		rdchk(OFS_CTRL, 32'h1, 1'b0);
		frame(68, 8'h02, 8'h11, 16'h8100, 1'b0, 1'b0, 1'b0, 1'b1);
		frame(16400, 8'h00, 8'h00, 16'h0800, 1'b0, 1'b1, 1'b0, 1'b0);
		rdchk(OFS_LAST_VEC, 32'h0007_ffe0, 1'b0);
		chk(32'(irq_o), 32'h0, "irq while masked");
		rdchk(OFS_INT_STAT, 32'h5, 1'b0);
		wr(OFS_INT_MASK, 32'h2);
		frame(20, 8'h00, 8'h00, 16'h0800, 1'b1, 1'b0, 1'b0, 1'b0);
		repeat (2) @(posedge clk_i);
		#1;
		chk(32'(irq_o), 32'h1, "irq raised");
		rdchk(OFS_INT_STAT, 32'h7, 1'b0);
		wr(OFS_INT_STAT, 32'h2);
		repeat (2) @(posedge clk_i);
		#1;
		chk(32'(irq_o), 32'h0, "irq cleared");
		rdchk(OFS_INT_STAT, 32'h5, 1'b0);
		rdchk(OFS_FRM_CNT, 32'(nfr), 1'b0);
		chk(frames, 32'(nfr), "frames counted");
		chk(bytes, 32'(exp_bytes), "bytes counted");
		chk(live, 32'(exp_live), "live cycles");
		wrap_up();
	end
endmodule : testbench

// File: txsv_cnt_model.sv
`timescale 1ns/1ps
module txsv_cnt_model
	import txsv_pkg::*;
(
	input  wire logic             clk_i,    // Transmit clock
	input  wire logic             nrst_i,   // Reset, active low
	input  wire logic [VEC_W-1:0] vec_i,    // Statistics vector
	input  wire logic             vld_i,    // Vector strobe
	output logic      [31:0]      frames_o, // Vectors taken
	output logic      [31:0]      bytes_o,  // Sum of reported lengths
	output logic      [31:0]      live_o    // Cycles with the byte flag up
);
	// Counts strobes only; between strobes only the live byte flag of the vector is used
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			frames_o <= 32'h0;
			bytes_o  <= 32'h0;
		end else if (vld_i) begin
			frames_o <= frames_o + 32'h1;
			bytes_o  <= bytes_o + 32'(vec_i[BIT_LEN_HI:BIT_LEN_LO]);
		end
	end

	// Live byte flag counts every cycle, not only at the strobe
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			live_o <= 32'h0;
		end else if (vec_i[BIT_BYTE]) begin
			live_o <= live_o + 32'h1;
		end
	end
endmodule : txsv_cnt_model

// File: txsv_parse.sv
`timescale 1ns/1ps
module txsv_parse
	import txsv_pkg::*;
(
	input  wire logic             clk_i,      // Transmit clock
	input  wire logic             rst_ni,     // Synchronised reset, active low
	input  wire logic             byte_i,     // Frame byte sent this cycle
	input  wire logic [7:0]       data_i,     // That byte
	input  wire logic             end_i,      // Frame finished, one cycle
	input  wire logic             vlan_en_i,  // Tagged frame detection on
	output logic      [LEN_W-1:0] len_o,      // Bytes counted so far
	output logic                  mcast_o,    // Group bit of destination
	output logic                  bcast_o,    // Destination all ones
	output logic                  ctrl_o,     // Control type seen
	output logic                  tagged_o    // Tag type seen
);

	logic [7:0] type_hi;

	// Counter sticks at the ceiling so frames longer than 16383 bytes report the maximum
	always_ff @(posedge clk_i or negedge rst_ni) begin
		if (!rst_ni) begin
			len_o <= '0;
		end else if (end_i) begin
			len_o <= '0;
		end else if (byte_i && len_o != LEN_MAX) begin
			len_o <= len_o + 14'h0001;
		end
	end

	always_ff @(posedge clk_i or negedge rst_ni) begin
		if (!rst_ni) begin
			mcast_o <= 1'b0;
			bcast_o <= 1'b1;
		end else if (end_i) begin
			mcast_o <= 1'b0;
			bcast_o <= 1'b1;
		end else if (byte_i && len_o <= IDX_DA_LAST) begin
			if (len_o == IDX_DA_FIRST) begin
				mcast_o <= data_i[0];
			end
			if (data_i != BCAST_BYTE) begin
				bcast_o <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_ni) begin
		if (!rst_ni) begin
			type_hi  <= '0;
			ctrl_o   <= 1'b0;
			tagged_o <= 1'b0;
		end else if (end_i) begin
			ctrl_o   <= 1'b0;
			tagged_o <= 1'b0;
		end else if (byte_i && len_o == IDX_TYPE_HI) begin
			type_hi <= data_i;
		end else if (byte_i && len_o == IDX_TYPE_LO) begin
			ctrl_o   <= {type_hi, data_i} == TYPE_CTRL;
			tagged_o <= vlan_en_i && {type_hi, data_i} == TYPE_VLAN;
		end
	end

endmodule : txsv_parse

// File: txsv_pkg.sv
package txsv_pkg;

	// Statistics vector layout
	localparam int unsigned VEC_W         = 32;
	localparam int unsigned LEN_W         = 14;
	localparam int unsigned BIT_PAUSE     = 31;
	localparam int unsigned BIT_BYTE      = 30;
	localparam int unsigned BIT_HD_HI     = 29;
	localparam int unsigned BIT_HD_LO     = 20;
	localparam int unsigned BIT_TAGGED    = 19;
	localparam int unsigned BIT_LEN_HI    = 18;
	localparam int unsigned BIT_LEN_LO    = 5;
	localparam int unsigned BIT_CTRL      = 4;
	localparam int unsigned BIT_UNDERRUN  = 3;
	localparam int unsigned BIT_MCAST     = 2;
	localparam int unsigned BIT_BCAST     = 1;
	localparam int unsigned BIT_OK        = 0;

	// Frame field positions, counted from the first destination address byte
	localparam logic [LEN_W-1:0] IDX_DA_FIRST = 14'h0000;
	localparam logic [LEN_W-1:0] IDX_DA_LAST  = 14'h0005;
	localparam logic [LEN_W-1:0] IDX_TYPE_HI  = 14'h000c;
	localparam logic [LEN_W-1:0] IDX_TYPE_LO  = 14'h000d;
	localparam logic [LEN_W-1:0] LEN_MAX      = 14'h3fff;
	localparam logic [15:0]      TYPE_CTRL    = 16'h8808;
	localparam logic [15:0]      TYPE_VLAN    = 16'h8100;
	localparam logic [7:0]       BCAST_BYTE   = 8'hff;

	// Register map (byte addresses)
	localparam logic [7:0] OFS_CTRL      = 8'h00;
	localparam logic [7:0] OFS_LAST_VEC  = 8'h04;
	localparam logic [7:0] OFS_FRM_CNT   = 8'h08;
	localparam logic [7:0] OFS_INT_STAT  = 8'h0c;
	localparam logic [7:0] OFS_INT_MASK  = 8'h10;

	// Control fields and interrupt bits
	localparam int unsigned CTRL_VLAN_EN = 0;
	localparam int unsigned INT_W        = 3;
	localparam int unsigned INT_FRAME    = 0;
	localparam int unsigned INT_UNDERRUN = 1;
	localparam int unsigned INT_ERROR    = 2;

	// Values after reset
	localparam logic             RST_VLAN_EN  = 1'b0;
	localparam logic [INT_W-1:0] RST_INT_MASK = 3'h0;
	localparam logic [VEC_W-1:0] RST_VEC      = 32'h0000_0000;

endpackage : txsv_pkg

// File: txsv_top.sv
`timescale 1ns/1ps
module txsv_top
	import txsv_pkg::*;
(
	input  wire logic             clk_i,          // Transmit clock, 125 MHz
	input  wire logic             nrst_i,         // Asynchronous reset, active low
	input  wire logic             frm_byte_i,     // A frame byte (DA to FCS) sent now
	input  wire logic [7:0]       frm_data_i,     // Byte being sent
	input  wire logic             frm_end_i,      // Frame finished, one cycle after last byte
	input  wire logic             frm_underrun_i, // Source failed to supply data
	input  wire logic             frm_error_i,    // Any other transmit error
	input  wire logic             frm_pause_sw_i, // Frame is a software-requested pause
	input  wire logic             psel_i,         // APB select
	input  wire logic             penable_i,      // APB enable
	input  wire logic             pwrite_i,       // APB direction
	input  wire logic [7:0]       paddr_i,        // APB byte address
	input  wire logic [31:0]      pwdata_i,       // APB write data
	output logic      [31:0]      prdata_o,       // APB read data
	output logic                  pready_o,       // APB ready
	output logic                  pslverr_o,      // APB error on unmapped address
	output logic      [VEC_W-1:0] stat_vec_o,     // Statistics vector
	output logic                  stat_vld_o,     // Vector strobe
	output logic                  irq_o           // Level interrupt
);

////////////////////////////////////////////////////////////////////////////////
	logic             rst_meta;
	logic             rst_n;

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

////////////////////////////////////////////////////////////////////////////////
	logic             vlan_en;
	logic [INT_W-1:0] int_mask;
	logic [INT_W-1:0] int_stat;
	logic [31:0]      frm_cnt;
	logic [LEN_W-1:0] p_len;
	logic             p_mcast;
	logic             p_bcast;
	logic             p_ctrl;
	logic             p_tagged;
	logic             underrun_seen;
	logic             error_seen;
	logic             pause_seen;
	logic             next_underrun;
	logic             next_error;
	logic             next_pause;
	logic             apb_acc;
	logic             apb_wr;
	logic             apb_bad;
	logic [31:0]      next_rdata;

	txsv_parse u_parse (
		.clk_i     (clk_i),
		.rst_ni    (rst_n),
		.byte_i    (frm_byte_i),
		.data_i    (frm_data_i),
		.end_i     (frm_end_i),
		.vlan_en_i (vlan_en),
		.len_o     (p_len),
		.mcast_o   (p_mcast),
		.bcast_o   (p_bcast),
		.ctrl_o    (p_ctrl),
		.tagged_o  (p_tagged)
	);

////////////////////////////////////////////////////////////////////////////////
	// Events in the end cycle still belong to the frame being closed
	assign next_underrun = underrun_seen | frm_underrun_i;
	assign next_error    = error_seen | frm_error_i;
	assign next_pause    = pause_seen | frm_pause_sw_i;

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			underrun_seen <= 1'b0;
			error_seen    <= 1'b0;
			pause_seen    <= 1'b0;
		end else if (frm_end_i) begin
			underrun_seen <= 1'b0;
			error_seen    <= 1'b0;
			pause_seen    <= 1'b0;
		end else begin
			underrun_seen <= next_underrun;
			error_seen    <= next_error;
			pause_seen    <= next_pause;
		end
	end

	// Live flag is not a data qualifier: it tracks bytes, not the strobe
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			stat_vec_o[BIT_BYTE] <= 1'b0;
		end else begin
			stat_vec_o[BIT_BYTE] <= frm_byte_i;
		end
	end

	// Full duplex only, so the half-duplex fields never carry anything
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			stat_vec_o[BIT_HD_HI:BIT_HD_LO] <= '0;
		end else begin
			stat_vec_o[BIT_HD_HI:BIT_HD_LO] <= '0;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			stat_vec_o[BIT_PAUSE]               <= 1'b0;
			stat_vec_o[BIT_TAGGED:BIT_OK]       <= RST_VEC[BIT_TAGGED:BIT_OK];
		end else if (frm_end_i) begin
			stat_vec_o[BIT_PAUSE]               <= next_pause;
			stat_vec_o[BIT_TAGGED]              <= p_tagged;
			stat_vec_o[BIT_LEN_HI:BIT_LEN_LO]   <= p_len;
			stat_vec_o[BIT_CTRL]                <= p_ctrl;
			stat_vec_o[BIT_UNDERRUN]            <= next_underrun;
			stat_vec_o[BIT_MCAST]               <= p_mcast;
			stat_vec_o[BIT_BCAST]               <= p_bcast;
			stat_vec_o[BIT_OK]                  <= !next_underrun && !next_error;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			stat_vld_o <= 1'b0;
		end else begin
			stat_vld_o <= frm_end_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			frm_cnt <= '0;
		end else if (stat_vld_o) begin
			frm_cnt <= frm_cnt + 32'h0000_0001;
		end
	end

////////////////////////////////////////////////////////////////////////////////
	// Ready is registered, so every access phase takes exactly two cycles
	assign apb_acc = psel_i && penable_i && !pready_o;
	assign apb_wr  = psel_i && penable_i && pready_o && pwrite_i && !pslverr_o;
	assign apb_bad = !(paddr_i == OFS_CTRL || paddr_i == OFS_LAST_VEC || paddr_i == OFS_FRM_CNT
		|| paddr_i == OFS_INT_STAT || paddr_i == OFS_INT_MASK);

	always_comb begin
		next_rdata = 32'h0000_0000;
		unique case (paddr_i)
			OFS_CTRL:     next_rdata[CTRL_VLAN_EN] = vlan_en;
			OFS_LAST_VEC: next_rdata = stat_vec_o;
			OFS_FRM_CNT:  next_rdata = frm_cnt;
			OFS_INT_STAT: next_rdata[INT_W-1:0] = int_stat;
			OFS_INT_MASK: next_rdata[INT_W-1:0] = int_mask;
			default:      next_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o  <= '0;
		end else begin
			pready_o  <= apb_acc;
			pslverr_o <= apb_acc && apb_bad;
			prdata_o  <= (apb_acc && !pwrite_i) ? next_rdata : 32'h0000_0000;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			vlan_en  <= RST_VLAN_EN;
			int_mask <= RST_INT_MASK;
		end else if (apb_wr && paddr_i == OFS_CTRL) begin
			vlan_en  <= pwdata_i[CTRL_VLAN_EN];
		end else if (apb_wr && paddr_i == OFS_INT_MASK) begin
			int_mask <= pwdata_i[INT_W-1:0];
		end
	end

////////////////////////////////////////////////////////////////////////////////
	logic [INT_W-1:0] int_set;
	logic [INT_W-1:0] int_clr;

	assign int_set[INT_FRAME]    = stat_vld_o;
	assign int_set[INT_UNDERRUN] = stat_vld_o && stat_vec_o[BIT_UNDERRUN];
	assign int_set[INT_ERROR]    = stat_vld_o && !stat_vec_o[BIT_OK];
	assign int_clr = (apb_wr && paddr_i == OFS_INT_STAT) ? pwdata_i[INT_W-1:0] : '0;

	// A new event beats a simultaneous write-one-to-clear
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			int_stat <= '0;
		end else begin
			int_stat <= (int_stat & ~int_clr) | int_set;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(((int_stat & ~int_clr) | int_set) & int_mask);
		end
	end

////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n);

	a_vld_follows_end: assert property (frm_end_i |=> stat_vld_o)
		else $error("strobe missing after frame end");
	a_vld_only_end: assert property (!frm_end_i |=> !stat_vld_o)
		else $error("strobe without frame end");
	a_pause_flag: assert property (stat_vld_o |-> stat_vec_o[BIT_PAUSE] == $past(next_pause))
		else $error("pause flag wrong");
	a_byte_live: assert property (##1 stat_vec_o[BIT_BYTE] == $past(frm_byte_i))
		else $error("byte flag not live");
	a_half_zero: assert property (##1 stat_vec_o[BIT_HD_HI:BIT_HD_LO] == '0)
		else $error("half duplex bits not zero");
	a_tag_needs_en: assert property (stat_vld_o && stat_vec_o[BIT_TAGGED] |-> $past(vlan_en, 2))
		else $error("tagged flag while disabled");
	a_len_capture: assert property (frm_end_i |=> stat_vec_o[BIT_LEN_HI:BIT_LEN_LO] == $past(p_len))
		else $error("length not captured");
	a_ctrl_flag: assert property (stat_vld_o |-> stat_vec_o[BIT_CTRL] == $past(p_ctrl))
		else $error("control flag wrong");
	a_underrun_ok: assert property (stat_vld_o && stat_vec_o[BIT_UNDERRUN] |-> !stat_vec_o[BIT_OK])
		else $error("underrun frame marked good");
	a_bcast_mcast: assert property (stat_vld_o && stat_vec_o[BIT_BCAST] |-> stat_vec_o[BIT_MCAST])
		else $error("broadcast not multicast");
	a_mcast_flag: assert property (frm_end_i |=> stat_vec_o[BIT_MCAST] == $past(p_mcast))
		else $error("multicast flag wrong");
	a_ok_flag: assert property (frm_end_i && !next_error && !next_underrun |=> stat_vec_o[BIT_OK])
		else $error("clean frame not marked good");
	a_vec_hold: assert property (!frm_end_i |=> $stable(stat_vec_o[BIT_TAGGED:BIT_OK]))
		else $error("vector changed between strobes");
	a_apb_ready: assert property (psel_i && penable_i && !pready_o |=> pready_o)
		else $error("apb ready late");
	a_irq_level: assert property (##1 irq_o == |($past(int_stat & ~int_clr | int_set) & $past(int_mask)))
		else $error("interrupt level wrong");

	// Register bus answers: one-cycle pulses, reads of zero outside them
	a_ready_pulse: assert property (pready_o |=> !pready_o)
		else $error("ready longer than one cycle");
	a_err_with_ready: assert property (pslverr_o |-> pready_o)
		else $error("error without ready");
	a_err_unmapped: assert property (apb_acc && apb_bad |=> pslverr_o)
		else $error("unmapped access not refused");
	a_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0000_0000)
		else $error("read data outside answer");
	a_rdata_vec: assert property (apb_acc && !pwrite_i && paddr_i == OFS_LAST_VEC |=> prdata_o == $past(stat_vec_o))
		else $error("last vector read wrong");
	a_rdata_cnt: assert property (apb_acc && !pwrite_i && paddr_i == OFS_FRM_CNT |=> prdata_o == $past(frm_cnt))
		else $error("frame count read wrong");
	a_ctrl_write: assert property (apb_wr && paddr_i == OFS_CTRL |=> vlan_en == $past(pwdata_i[CTRL_VLAN_EN]))
		else $error("control write lost");
	a_mask_write: assert property (apb_wr && paddr_i == OFS_INT_MASK |=> int_mask == $past(pwdata_i[INT_W-1:0]))
		else $error("mask write lost");
	a_err_no_write: assert property (pready_o && pslverr_o |=> $stable(vlan_en) && $stable(int_mask))
		else $error("refused write landed");

	// Counters, status and interrupt
	a_cnt_step: assert property (stat_vld_o |=> frm_cnt == $past(frm_cnt) + 32'h0000_0001)
		else $error("frame count did not step");
	a_cnt_hold: assert property (!stat_vld_o |=> $stable(frm_cnt))
		else $error("frame count moved without strobe");
	a_stat_frame: assert property (stat_vld_o |=> int_stat[INT_FRAME])
		else $error("frame status not set");
	a_stat_clear: assert property (apb_wr && paddr_i == OFS_INT_STAT && !stat_vld_o
		|=> (int_stat & $past(pwdata_i[INT_W-1:0])) == '0)
		else $error("status bit not cleared");
	a_irq_masked: assert property (int_mask == '0 |=> !irq_o)
		else $error("interrupt while all masked");

	// Per-frame capture while bytes flow
	a_len_step: assert property (frm_byte_i && !frm_end_i && p_len != LEN_MAX |=> p_len == $past(p_len) + 14'h0001)
		else $error("length did not count");
	a_len_sat: assert property (frm_byte_i && !frm_end_i && p_len == LEN_MAX |=> p_len == LEN_MAX)
		else $error("length wrapped past ceiling");
	a_len_clear: assert property (frm_end_i |=> p_len == '0)
		else $error("length not restarted");
	a_mcast_first: assert property (frm_byte_i && !frm_end_i && p_len == IDX_DA_FIRST
		|=> p_mcast == $past(frm_data_i[0]))
		else $error("group bit not taken");
	a_bcast_drop: assert property (frm_byte_i && !frm_end_i && p_len <= IDX_DA_LAST && frm_data_i != BCAST_BYTE
		|=> !p_bcast)
		else $error("broadcast kept after other byte");
	a_flags_clear: assert property (stat_vld_o |-> !underrun_seen && !error_seen && !pause_seen)
		else $error("frame flags leaked into next frame");
	a_underrun_keep: assert property (frm_underrun_i && !frm_end_i |=> underrun_seen)
		else $error("underrun not remembered");
	a_error_keep: assert property (frm_error_i && !frm_end_i |=> error_seen)
		else $error("error not remembered");
	a_pause_keep: assert property (frm_pause_sw_i && !frm_end_i |=> pause_seen)
		else $error("pause not remembered");

	// Each half-duplex bit on its own, so a stray driver points at the bit
	for (genvar b = BIT_HD_LO; b <= BIT_HD_HI; b++) begin : g_hd_zero
		a_hd_bit: assert property (!stat_vec_o[b])
			else $error("half duplex bit set");
	end

	c_frame: cover property (stat_vld_o && stat_vec_o[BIT_OK]);
	c_underrun: cover property (stat_vld_o && stat_vec_o[BIT_UNDERRUN]);
	c_tagged: cover property (stat_vld_o && stat_vec_o[BIT_TAGGED]);
	c_irq: cover property (!irq_o ##1 irq_o);
	c_saturate: cover property (stat_vld_o && stat_vec_o[BIT_LEN_HI:BIT_LEN_LO] == LEN_MAX);

endmodule : txsv_top
